//--- design/l2_policy_pkg.sv
// Purpose: Shared constants and carriers for the level-2 cache policy control block
// Assumes: 32-bit control register, bit 0 is the least significant bit
// Notes:   Field positions follow the control register layout
package l2_policy_pkg;
   // Field positions in the control register
   localparam int unsigned POS_ENABLE     = 0;
   localparam int unsigned POS_DATA_ONLY  = 9;
   localparam int unsigned POS_INVALIDATE = 10;
   localparam int unsigned POS_LOWPOWER   = 11;
   localparam int unsigned POS_WR_THROUGH = 12;
   localparam int unsigned POS_TEST_SUPP  = 13;
   localparam int unsigned POS_HOLD_LO    = 14;
   localparam int unsigned POS_HOLD_HI    = 15;
   localparam int unsigned POS_DLL_SLOW   = 16;
   localparam int unsigned POS_DIFF_CLK   = 17;
   localparam int unsigned POS_INSTR_ONLY = 21;
   // Hard reset clears the register
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   // Mask of bits this block stores; all others read as zero
   localparam logic [31:0] CTRL_MASK      = 32'h0023_FE01;
   // Output hold encoding for this package (0.8 ns)
   localparam logic [1:0]  HOLD_0P8NS     = 2'h1;
   // Invalidate sweep length in lines
   localparam int unsigned LINES_DEFAULT  = 1024;

   // Transaction kinds seen by the cache unit
   typedef enum logic [2:0] {
      TR_IFETCH,
      TR_DLOAD,
      TR_DSTORE,
      TR_PUSH_FLUSH,
      TR_ZERO,
      TR_STORE_1BEAT
   } tr_kind_e;

   // Request from the cache pipeline
   typedef struct packed {
      logic     valid;
      tr_kind_e kind;
      logic     hit;
   } cache_req_s;

   // Policy decision returned to the pipeline
   typedef struct packed {
      logic active;
      logic allocate;
      logic to_bus;
      logic mark_dirty;
      logic mark_valid;
      logic inval_line;
   } cache_dec_s;
endpackage

//--- design/l2_cache_policy_control_bits.sv
// Purpose: Holds the policy bits of the cache control register and turns them into per-transaction decisions
// Assumes: Register written through a special-register port; power state pins asynchronous, synchronised to the system clock
// Notes:   Invalidate sweeps line status indices one per cycle and self-clears
`timescale 1ns/10ps

// How it works
// R1 - Data-only bit stops instruction miss reloads
// R2 - Both only-bits set locks cache allocation; test-mode push misses still allocate here
// R3 - Invalidate bit clears every line status
// R4 - Software invalidates only with cache disabled
// R5 - Low-power bit drives RAM sleep in nap/sleep
// R6 - Avoid low-power bit during nap snooping
// R7 - Write-through sends every write to bus
// R8 - Write-through lines are marked clean
// R9 - Never set write-through after enabling
// R10 - Test mode keeps flush pushes in cache
// R11 - Test mode hides zero stores and single-beat store misses
// R12 - Output hold field selects RAM hold time
// R13 - DLL slow bit lengthens tap delay
// R14 - Differential clock bit left clear here
// R15 - Enable takes effect from next transaction; here requests see it only after a request-free cycle following the write
// R16 - Instruction-only bit restricts reloads to fetches
// R17 - Fields hold until rewrite or reset, except invalidate, which self-clears at sweep end
module l2_cache_policy_control_bits
   import l2_policy_pkg::*;
#(
   parameter int unsigned LINES = LINES_DEFAULT
) (
   // Clock and reset
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST,
   // Control register port
   input  wire logic        I_REG_WR,
   input  wire logic [31:0] I_REG_WDATA,
   output logic      [31:0] O_REG_RDATA,
   // Power state
   input  wire logic        I_NAP,
   input  wire logic        I_SLEEP,
   // Cache pipeline request and decision
   input  wire cache_req_s  I_REQ,
   output cache_dec_s       O_DEC,
   // Line status clear port
   output logic             O_LINE_CLR,
   output logic [$clog2(LINES)-1:0] O_LINE_IDX,
   // RAM interface controls
   output logic             O_CACHE_RAM_SLEEP,
   output logic      [1:0]  O_OUTPUT_HOLD_SEL,
   output logic             O_DLL_SLOW_TAPS,
   output logic             O_DIFF_CLOCK_MODE
);
   // Sweep index width and the index that ends a sweep
   localparam int unsigned IW = $clog2(LINES);
   localparam logic [IW-1:0] LAST_IDX = IW'(LINES - 1);

   // Invalidate sequencer states
   typedef enum logic {ST_IDLE, ST_SWEEP} inv_state_e;

   // Control register
   logic [31:0]   ctrl_r;
   logic [31:0]   ctrl_nxt;

   // Invalidate sweep
   inv_state_e    inv_state_r;
   inv_state_e    inv_state_nxt;
   logic [IW-1:0] idx_r;
   logic [IW-1:0] idx_nxt;

   // Enable as seen by the transaction in flight
   logic          enable_live_r;

   // Power state pins, their synchronised copies and the RAM sleep output
   wire  [1:0]    pwr_pin = {I_SLEEP, I_NAP};
   wire  [1:0]    pwr_sync;
   logic          sleep_r;

   // Registered decision
   cache_dec_s    dec_r;
   cache_dec_s    dec_nxt;

   // Software ordering (invalidate only while disabled, write-through only
   // before enable) is not policed here; breaking it loses dirty data

   // Named fields of the stored register
   wire cache_enable_bit  = ctrl_r[POS_ENABLE];
   wire data_only_alloc   = ctrl_r[POS_DATA_ONLY];
   wire instr_only_alloc  = ctrl_r[POS_INSTR_ONLY];
   wire ram_lowpower_auto = ctrl_r[POS_LOWPOWER];
   wire write_through_sel = ctrl_r[POS_WR_THROUGH];
   wire test_support_mode = ctrl_r[POS_TEST_SUPP];

   // Write stores the policy bits; invalidate bit self-clears at end of sweep
   wire sweep_done   = (inv_state_r == ST_SWEEP) && (idx_r == LAST_IDX);
   wire inv_start    = I_REG_WR && I_REG_WDATA[POS_INVALIDATE];     // see R3
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (I_REG_WR) begin
         // Unstored fields never reach the register, so they read back as zero
         ctrl_nxt = I_REG_WDATA & CTRL_MASK;                      // see R17
      end
      // A fresh invalidate write on the last sweep cycle wins over the self-clear
      if (sweep_done && !inv_start) begin
         ctrl_nxt[POS_INVALIDATE] = 1'b0;
      end
   end

   // Invalidate sweep walks every line index once
   always_comb begin
      inv_state_nxt = inv_state_r;
      idx_nxt       = idx_r;
      case (inv_state_r)
         ST_IDLE: begin
            if (inv_start) begin
               inv_state_nxt = ST_SWEEP;                          // see R3
               idx_nxt       = '0;
            end
         end
         // Writes during a sweep do not restart it; only idle accepts a start
         ST_SWEEP: begin
            if (sweep_done) begin
               inv_state_nxt = ST_IDLE;
            end else begin
               idx_nxt = idx_r + IW'(1);
            end
         end
         default: inv_state_nxt = ST_IDLE;
      endcase
   end

   // Register and sweep state
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         ctrl_r      <= CTRL_RESET;
         inv_state_r <= ST_IDLE;
         idx_r       <= '0;
      end else begin
         ctrl_r      <= ctrl_nxt;
         inv_state_r <= inv_state_nxt;
         idx_r       <= idx_nxt;
      end
   end

   // Enable is sampled only between transactions, so a request in flight keeps its mode
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         enable_live_r <= 1'b0;
      end else if (!I_REQ.valid) begin
         enable_live_r <= cache_enable_bit;                       // see R15
      end
   end

   // Power state pins are asynchronous to this clock: two flip-flops per pin,
   // and only the second stage is read, so a metastable first stage stays hidden
   for (genvar g = 0; g < 2; g++) begin : g_sync
      logic s1_r;
      logic s2_r;
      always_ff @(posedge I_CLK_SYS) begin
         if (I_RST) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
         end else begin
            s1_r <= pwr_pin[g];
            s2_r <= s1_r;
         end
      end
      assign pwr_sync[g] = s2_r;
   end

   // RAM sleep follows nap or sleep only while automatic control is on
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         sleep_r <= 1'b0;
      end else begin
         sleep_r <= ram_lowpower_auto && (|pwr_sync);             // see R5
      end
   end

   // Allocation gating by traffic type
   wire is_instr    = (I_REQ.kind == TR_IFETCH);
   wire is_flush    = (I_REQ.kind == TR_PUSH_FLUSH);
   wire is_write    = (I_REQ.kind == TR_DSTORE) || is_flush || (I_REQ.kind == TR_STORE_1BEAT);
   wire instr_ok    = !data_only_alloc;                           // see R1
   wire data_ok     = !instr_only_alloc;                          // see R16
   // Both bits set leaves neither allowed, which is the locked case
   wire alloc_ok    = is_instr ? instr_ok : data_ok;              // see R2
   wire ts_flush    = test_support_mode && is_flush;              // see R10
   wire ts_quiet    = test_support_mode && ((I_REQ.kind == TR_ZERO) ||
                      ((I_REQ.kind == TR_STORE_1BEAT) && !I_REQ.hit)); // see R11

   // Decision per request, registered so data outputs come from flip-flops
   always_comb begin
      dec_nxt = '0;
      if (I_REQ.valid && enable_live_r && inv_state_r == ST_IDLE) begin
         dec_nxt.active     = 1'b1;
         // Hits never allocate; test-mode pushes allocate only on a miss
         dec_nxt.allocate   = !I_REQ.hit && (alloc_ok || ts_flush);
         dec_nxt.mark_valid = I_REQ.hit || dec_nxt.allocate;
         // Write-through pushes writes to the bus; test mode suppresses flush pushes, zero stores and single-beat store misses
         dec_nxt.to_bus     = !ts_flush && !ts_quiet &&
                              (write_through_sel ? is_write : (is_flush || !I_REQ.hit)); // see R7
         // Write-back marks written lines dirty; write-through keeps them clean
         dec_nxt.mark_dirty = is_write && !is_flush && !write_through_sel && dec_nxt.mark_valid; // see R8
         dec_nxt.inval_line = is_flush && I_REQ.hit && !ts_flush; // see R10
      end
   end

   // Decision register
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         dec_r <= '0;
      end else begin
         dec_r <= dec_nxt;
      end
   end

   // Outputs; hold, slow taps and differential mode are passed straight to the RAM interface
   assign O_REG_RDATA       = ctrl_r;                             // see R17
   assign O_DEC             = dec_r;
   assign O_LINE_CLR        = (inv_state_r == ST_SWEEP);          // see R3
   assign O_LINE_IDX        = idx_r;
   assign O_CACHE_RAM_SLEEP = sleep_r;
   assign O_OUTPUT_HOLD_SEL = ctrl_r[POS_HOLD_HI:POS_HOLD_LO];    // see R12
   assign O_DLL_SLOW_TAPS   = ctrl_r[POS_DLL_SLOW];               // see R13
   assign O_DIFF_CLOCK_MODE = ctrl_r[POS_DIFF_CLK];               // see R14
endmodule

//--- bench/l2_policy_checker.sv
// Purpose: Watches the policy block ports for decision and register faults
// Assumes: Decisions answer the request of the previous cycle
// Notes:   Sleep path is three clocks from the power pins
`timescale 1ns/10ps
module l2_policy_checker
   import l2_policy_pkg::*;
#(
   parameter int unsigned LINES = LINES_DEFAULT
) (
   input wire logic        I_CLK_SYS,
   input wire logic        I_RST,
   input wire logic        I_REG_WR,
   input wire logic [31:0] I_REG_WDATA,
   input wire logic [31:0] O_REG_RDATA,
   input wire logic        I_NAP,
   input wire logic        I_SLEEP,
   input wire cache_req_s  I_REQ,
   input wire cache_dec_s  O_DEC,
   input wire logic        O_LINE_CLR,
   input wire logic [$clog2(LINES)-1:0] O_LINE_IDX,
   input wire logic        O_CACHE_RAM_SLEEP,
   input wire logic [1:0]  O_OUTPUT_HOLD_SEL,
   input wire logic        O_DLL_SLOW_TAPS,
   input wire logic        O_DIFF_CLOCK_MODE
);
   // Shorthand; fields are judged as they stood when the request was taken
   wire logic [31:0] r = O_REG_RDATA;
   wire logic        v = I_REQ.valid;
   wire tr_kind_e    k = I_REQ.kind;
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   property p_wr; I_REG_WR |=> r == ($past(I_REG_WDATA) & CTRL_MASK); endproperty
   property p_knob; {O_DIFF_CLOCK_MODE, O_DLL_SLOW_TAPS, O_OUTPUT_HOLD_SEL} == r[17:14]; endproperty
   property p_do; $past(v && k == TR_IFETCH && r[9]) |-> !O_DEC.allocate; endproperty
   property p_clean; $past(v && r[12]) |-> !O_DEC.mark_dirty; endproperty
   property p_wt; $past(v && k == TR_DSTORE && r[12] && !r[13]) && O_DEC.active |-> O_DEC.to_bus; endproperty
   property p_push; $past(v && k == TR_PUSH_FLUSH && r[13]) |-> !O_DEC.to_bus && !O_DEC.inval_line; endproperty
   property p_step; O_LINE_CLR && O_LINE_IDX != LINES - 1 |=> O_LINE_CLR && O_LINE_IDX == $past(O_LINE_IDX) + 1'b1;
   endproperty
   property p_end; O_LINE_CLR && O_LINE_IDX == LINES - 1 |=> !O_LINE_CLR ##[0:1] !r[10]; endproperty
   property p_quiet; $past(O_LINE_CLR) |-> !O_DEC.active; endproperty
   // Sync stages are cleared by reset, so the pin history must be clear of it
   property p_sleep; !$past(I_RST) && !$past(I_RST, 2) && !$past(I_RST, 3) |->
      O_CACHE_RAM_SLEEP == ($past(r[11]) && ($past(I_NAP, 3) || $past(I_SLEEP, 3))); endproperty
   a_wr: assert property (p_wr) else $error("register write not held");
   a_knob: assert property (p_knob) else $error("RAM knobs differ from register");
   a_do: assert property (p_do) else $error("fetch miss allocated");
   a_clean: assert property (p_clean) else $error("write-through line dirty");
   a_wt: assert property (p_wt) else $error("write-through store kept off bus");
   a_push: assert property (p_push) else $error("test push left cache");
   a_step: assert property (p_step) else $error("sweep index skipped");
   a_end: assert property (p_end) else $error("sweep did not finish");
   a_quiet: assert property (p_quiet) else $error("request served during sweep");
   a_sleep: assert property (p_sleep) else $error("RAM sleep wrong");
   c_sweep: cover property ($rose(O_LINE_CLR));
   c_sleep: cover property ($rose(O_CACHE_RAM_SLEEP));
   c_alloc: cover property (O_DEC.active && O_DEC.allocate);
endmodule
bind l2_cache_policy_control_bits l2_policy_checker #(.LINES(LINES)) checker_i (
   .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_REG_WR(I_REG_WR), .I_REG_WDATA(I_REG_WDATA),
   .O_REG_RDATA(O_REG_RDATA), .I_NAP(I_NAP), .I_SLEEP(I_SLEEP), .I_REQ(I_REQ), .O_DEC(O_DEC),
   .O_LINE_CLR(O_LINE_CLR), .O_LINE_IDX(O_LINE_IDX), .O_CACHE_RAM_SLEEP(O_CACHE_RAM_SLEEP),
   .O_OUTPUT_HOLD_SEL(O_OUTPUT_HOLD_SEL), .O_DLL_SLOW_TAPS(O_DLL_SLOW_TAPS), .O_DIFF_CLOCK_MODE(O_DIFF_CLOCK_MODE));

//--- bench/sram_ram_model.sv
// Purpose: Sleep and hold view of the cache data RAMs
// Assumes: Sleep pin sampled on the system clock
// Notes:   Timing of the RAM itself is not modelled
`timescale 1ns/10ps
module sram_ram_model
   import l2_policy_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_zz,
   input  wire logic [1:0] i_hold,
   output logic            o_asleep,
   output logic            o_hold_ok
);
   // RAM drops into low power one clock after its sleep pin
   always_ff @(posedge i_clk) begin
      o_asleep <= i_zz;
   end
   // Only the 0.8 ns hold suits these RAMs
   assign o_hold_ok = (i_hold == HOLD_0P8NS);
endmodule

//--- bench/tb_l2_cache_policy_control_bits.sv
// Purpose: Drives register and request ports and judges decisions
// Assumes: One idle cycle after each write lets enable settle
// Notes:   Sweep cut to 16 lines to keep the run short
`timescale 1ns/10ps
module tb_l2_cache_policy_control_bits
   import l2_policy_pkg::*;
();
   logic I_CLK_SYS = 1'b0, I_RST = 1'b1, I_REG_WR = 1'b0, I_NAP = 1'b0, I_SLEEP = 1'b0;
   logic [31:0] I_REG_WDATA = 32'h0000_0000, O_REG_RDATA;
   cache_req_s  I_REQ = '0;
   cache_dec_s  O_DEC;
   logic        O_LINE_CLR, O_CACHE_RAM_SLEEP, O_DLL_SLOW_TAPS, O_DIFF_CLOCK_MODE, asleep, hold_ok;
   logic [3:0]  O_LINE_IDX;
   logic [1:0]  O_OUTPUT_HOLD_SEL;
   int          errors = 0, checked = 0;
   always #20 I_CLK_SYS = ~I_CLK_SYS;
   l2_cache_policy_control_bits #(.LINES(16)) uut (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_REG_WR(I_REG_WR),
      .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA), .I_NAP(I_NAP), .I_SLEEP(I_SLEEP), .I_REQ(I_REQ),
      .O_DEC(O_DEC), .O_LINE_CLR(O_LINE_CLR), .O_LINE_IDX(O_LINE_IDX), .O_CACHE_RAM_SLEEP(O_CACHE_RAM_SLEEP),
      .O_OUTPUT_HOLD_SEL(O_OUTPUT_HOLD_SEL), .O_DLL_SLOW_TAPS(O_DLL_SLOW_TAPS), .O_DIFF_CLOCK_MODE(O_DIFF_CLOCK_MODE));
   sram_ram_model ram (.i_clk(I_CLK_SYS), .i_zz(O_CACHE_RAM_SLEEP), .i_hold(O_OUTPUT_HOLD_SEL),
      .o_asleep(asleep), .o_hold_ok(hold_ok));
   task cyc(input int n);
      repeat (n) @(posedge I_CLK_SYS);
      #1;
   endtask
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Write then idle a cycle, so strobes never toggle twice in one step
   task wr(input logic [31:0] d);
      I_REG_WR = 1'b1;
      I_REG_WDATA = d;
      cyc(1);
      I_REG_WR = 1'b0;
      cyc(1);
   endtask
   // Disable, set policy bits, then enable; masked fields are the uncertain ones
   task dec(input logic [31:0] c, input tr_kind_e k, input logic h, input logic [5:0] e, input logic [5:0] m);
      wr(32'h0000_0000);
      wr(c & 32'hFFFF_FFFE);
      wr(c);
      I_REQ = '{1'b1, k, h};
      cyc(1);
      I_REQ.valid = 1'b0;
      chk("decision", O_DEC & m, e & m);
   endtask
   task t_reg();
      chk("regs", O_REG_RDATA, CTRL_RESET);
      wr(32'hFFFD_FBFE);
      chk("regs", O_REG_RDATA, 32'h0021_FA00);
      chk("knobs", {O_OUTPUT_HOLD_SEL, O_DLL_SLOW_TAPS, O_DIFF_CLOCK_MODE}, 32'h0000_000E);
      wr(32'h0000_4000);
      chk("hold", {hold_ok, O_DLL_SLOW_TAPS, O_DIFF_CLOCK_MODE}, 3'h4);
   endtask
   // Requests run back to back across the disable, so enable stays live into the sweep
   task t_inval();
      int n;
      n = 0;
      wr(32'h0000_0001);
      I_REQ = '{1'b1, TR_DLOAD, 1'b0};
      wr(32'h0000_0000);
      I_REG_WDATA = 32'h0000_0400;
      I_REG_WR = 1'b1;
      cyc(1);
      I_REG_WR = 1'b0;
      while (O_LINE_CLR === 1'b1 && n < 40) begin
         chk("sweep index", O_LINE_IDX, n);
         n++;
         cyc(1);
         chk("sweep active", O_DEC.active, 1'b0);
      end
      cyc(1);
      I_REQ.valid = 1'b0;
      chk("sweep", n, 32'h0000_0010);
      chk("regs", O_REG_RDATA, 32'h0000_0000);
   endtask
   task t_alloc();
      dec(32'h0000_0000, TR_IFETCH, 1'b0, 6'h00, 6'h20);
      dec(32'h0000_0201, TR_IFETCH, 1'b0, 6'h28, 6'h3F);
      dec(32'h0000_0201, TR_DLOAD, 1'b0, 6'h3A, 6'h3F);
      dec(32'h0020_0201, TR_DLOAD, 1'b0, 6'h28, 6'h3F);
      dec(32'h0020_0201, TR_IFETCH, 1'b1, 6'h22, 6'h3F);
      dec(32'h0020_0001, TR_DLOAD, 1'b0, 6'h28, 6'h3F);
      dec(32'h0020_0001, TR_IFETCH, 1'b0, 6'h3A, 6'h3F);
   endtask
   task t_write();
      dec(32'h0000_1001, TR_DSTORE, 1'b1, 6'h2A, 6'h3F);
      dec(32'h0000_1001, TR_DSTORE, 1'b0, 6'h3A, 6'h3F);
      dec(32'h0000_0001, TR_DSTORE, 1'b1, 6'h26, 6'h3F);
      dec(32'h0000_2001, TR_PUSH_FLUSH, 1'b1, 6'h22, 6'h3F);
      dec(32'h0000_2001, TR_PUSH_FLUSH, 1'b0, 6'h32, 6'h3F);
      dec(32'h0000_0001, TR_PUSH_FLUSH, 1'b1, 6'h2B, 6'h3F);
      dec(32'h0000_2001, TR_ZERO, 1'b0, 6'h20, 6'h28);
      dec(32'h0000_2001, TR_STORE_1BEAT, 1'b0, 6'h20, 6'h28);
      dec(32'h0000_0001, TR_STORE_1BEAT, 1'b0, 6'h28, 6'h28);
   endtask
   task t_sleep();
      wr(32'h0000_0800);
      I_NAP = 1'b1;
      cyc(5);
      chk("ram asleep", asleep, 1'b1);
      I_NAP = 1'b0;
      cyc(5);
      chk("ram asleep", asleep, 1'b0);
      I_SLEEP = 1'b1;
      cyc(5);
      chk("ram asleep", asleep, 1'b1);
      wr(32'h0000_0000);
      chk("sleep", O_CACHE_RAM_SLEEP, 1'b0);
      I_SLEEP = 1'b0;
   endtask
   task end_sim();
      if (errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Run needs well under a thousand cycles; this cuts a hang
   initial begin
      #100000;
      errors++;
      end_sim();
   end
   initial begin
      cyc(16);
      I_RST = 1'b0;
      t_reg();
      t_inval();
      t_alloc();
      t_write();
      t_sleep();
      end_sim();
   end
endmodule
